// ### verilog/bfd_consts.svh
// Field positions, opcodes, register offsets and counts of the busy-flag
// descriptor link. Assumes inclusion by bare name from each design file.
`ifndef BFD_CONSTS_SVH
`define BFD_CONSTS_SVH
// ************************************************************
// Descriptor word fields
// ************************************************************
`define BFD_F_AVAIL    31
`define BFD_F_POL      30
`define BFD_F_RSVD     29
`define BFD_F_ADDRD    28
`define BFD_F_BYTE1    27
`define BFD_F_POS_HI   26
`define BFD_F_POS_LO   24
`define BFD_F_LADR_HI  23
`define BFD_F_LADR_LO  16
`define BFD_F_MODE_HI  23
`define BFD_F_MODE_LO  20
`define BFD_F_DUM_HI   19
`define BFD_F_DUM_LO   16
`define BFD_F_RDOP_HI  15
`define BFD_F_RDOP_LO  8
`define BFD_F_WROP_HI  7
`define BFD_F_WROP_LO  0
// ************************************************************
// Link opcodes and values
// ************************************************************
`define BFD_OP_DESC    8'h5a
`define BFD_OP_NONE    8'h00
`define BFD_BUSY_CYC   1000
// ************************************************************
// Controller register map
// ************************************************************
`define BFD_A_CTRL     8'h00
`define BFD_A_STAT     8'h04
`define BFD_A_DESC     8'h08
`define BFD_A_POLLS    8'h0c
`define BFD_A_WDATA    8'h10
`define BFD_C_FETCH    0
`define BFD_C_POLL     1
`define BFD_C_LANE_HI  4
`define BFD_C_LANE_LO  2
`define BFD_C_WRITE    5
`define BFD_RESP_OK    2'b00
`define BFD_RESP_ERR   2'b10
`endif

// ### verilog/bfd_pkg.sv
// Types shared by both ends of the busy-flag descriptor link.
// Assumes nothing of its surroundings.
package bfd_pkg;
	typedef enum logic [2:0] {
		LANE_1S = 3'b000,
		LANE_4S = 3'b001,
		LANE_4D = 3'b010,
		LANE_8S = 3'b011,
		LANE_8D = 3'b100
	} bfd_lane_type;
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_WAIT = 2'b01,
		DEV_ANS  = 2'b10
	} bfd_dev_st_type;
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_SEND = 2'b01,
		HOST_WAIT = 2'b10
	} bfd_host_st_type;
	typedef enum logic [1:0] {
		JOB_FETCH = 2'b00,
		JOB_POLL  = 2'b01,
		JOB_WRITE = 2'b10
	} bfd_job_type;
endpackage : bfd_pkg

// ### verilog/bfd_link_if.sv
// Command and answer link between flash controller and flash device.
// Assumes both ends run on one common clock.
interface bfd_link_if;
	logic                  cmd_valid;
	logic                  cmd_ready;
	logic [7:0]            cmd_op;
	logic [31:0]           cmd_addr;
	logic                  cmd_has_addr;
	logic [3:0]            cmd_dummy;
	bfd_pkg::bfd_lane_type cmd_lane;
	logic [7:0]            cmd_wdata;
	logic                  rsp_valid;
	logic [31:0]           rsp_data;
	logic                  rsp_err;
	modport dev (
		input  cmd_valid, cmd_op, cmd_addr, cmd_has_addr,
		input  cmd_dummy, cmd_lane, cmd_wdata,
		output cmd_ready, rsp_valid, rsp_data, rsp_err
	);
	modport host (
		output cmd_valid, cmd_op, cmd_addr, cmd_has_addr,
		output cmd_dummy, cmd_lane, cmd_wdata,
		input  cmd_ready, rsp_valid, rsp_data, rsp_err
	);
endinterface : bfd_link_if

// ### verilog/bfd_device.sv
// Flash device end: publishes the busy-flag descriptor word and answers
// status reads and writes. Assumes the controller waits for each answer.
`include "bfd_consts.svh"
module bfd_device #(
	parameter bit         FLAG_PRESENT = 1'b1,
	parameter bit         POL_INV      = 1'b0,
	parameter bit         ADDRESSED    = 1'b0,
	parameter bit         BYTE1        = 1'b0,
	parameter int         ADDR_BYTES   = 3,
	parameter logic [2:0] FLAG_POS     = 3'h0,
	parameter logic [7:0] LOCAL_ADDR   = 8'h05,
	parameter logic [3:0] MODES        = 4'h0,
	parameter logic [3:0] DUMMY        = 4'h8,
	parameter logic [7:0] RD_OP        = 8'h05,
	parameter logic [7:0] WR_OP        = 8'h01,
	parameter int         BUSY_CYCLES  = `BFD_BUSY_CYC
) (
	input  wire logic clk,
	input  wire logic rst_b,
	bfd_link_if.dev   link,
	input  wire logic start_op,
	output logic      busy
);
	typedef struct packed {
		bfd_pkg::bfd_dev_st_type st;
		logic [3:0]              cnt;
		logic [31:0]             data;
		logic                    err;
		logic [7:0]              stat;
		logic [15:0]             busy_cnt;
	} bfd_dev_state_type;
	bfd_dev_state_type state_reg;
	bfd_dev_state_type state_next;
	logic [31:0] desc;
	logic        byte1_eff;
	logic [7:0]  sel;
	logic        addr_ok;
	logic [7:0]  stat_out;
	logic [7:0]  pos_mask;
// ************************************************************
// Descriptor word
// ************************************************************
	assign byte1_eff = BYTE1 && (ADDR_BYTES != 1);
	always_comb begin
		desc = 32'h0;
		if (FLAG_PRESENT) begin
			desc[`BFD_F_AVAIL] = 1'b1;
			desc[`BFD_F_POL] = POL_INV;
			desc[`BFD_F_RSVD] = 1'b0;
			desc[`BFD_F_ADDRD] = ADDRESSED;
			desc[`BFD_F_BYTE1] = byte1_eff;
			desc[`BFD_F_POS_HI:`BFD_F_POS_LO] = FLAG_POS;
			if (ADDRESSED) begin
				desc[`BFD_F_LADR_HI:`BFD_F_LADR_LO] = LOCAL_ADDR;
			end else begin
				// Bit 3 of MODES is 8D, down to bit 0 for 4S
				desc[`BFD_F_MODE_HI:`BFD_F_MODE_LO] = MODES;
				desc[`BFD_F_DUM_HI:`BFD_F_DUM_LO] = DUMMY;
			end
			desc[`BFD_F_RDOP_HI:`BFD_F_RDOP_LO] = RD_OP;
			desc[`BFD_F_WROP_HI:`BFD_F_WROP_LO] = WR_OP;
		end
	end
// ************************************************************
// Command decode
// ************************************************************
	assign busy = state_reg.busy_cnt != 16'h0;
	assign pos_mask = 8'h01 << FLAG_POS;
	assign stat_out = (state_reg.stat & ~pos_mask)
		| ({8{busy ^ POL_INV}} & pos_mask);
	assign sel = byte1_eff ? link.cmd_addr[15:8] : link.cmd_addr[7:0];
	assign addr_ok = ADDRESSED ? (link.cmd_has_addr && sel == LOCAL_ADDR)
		: !link.cmd_has_addr;
	assign link.cmd_ready = state_reg.st == bfd_pkg::DEV_IDLE;
	assign link.rsp_valid = state_reg.st == bfd_pkg::DEV_ANS;
	assign link.rsp_data = state_reg.data;
	assign link.rsp_err = state_reg.err;
	always_comb begin
		state_next = state_reg;
		if (start_op && !busy) begin
			state_next.busy_cnt = 16'(BUSY_CYCLES);
		end else if (busy) begin
			state_next.busy_cnt = state_reg.busy_cnt - 16'h1;
		end
		unique case (state_reg.st)
			bfd_pkg::DEV_IDLE: begin
				if (link.cmd_valid) begin
					state_next.cnt = 4'h0;
					state_next.data = 32'h0;
					state_next.err = 1'b0;
					if (link.cmd_op == `BFD_OP_DESC) begin
						state_next.data = desc;
					end else if (FLAG_PRESENT && RD_OP != `BFD_OP_NONE
						&& link.cmd_op == RD_OP && addr_ok) begin
						state_next.data = {24'h0, stat_out};
						if (!ADDRESSED
							&& link.cmd_lane != bfd_pkg::LANE_1S) begin
							state_next.cnt = DUMMY;
						end
					end else if (FLAG_PRESENT && WR_OP != `BFD_OP_NONE
						&& link.cmd_op == WR_OP && addr_ok) begin
						state_next.stat = (link.cmd_wdata & ~pos_mask)
							| (state_reg.stat & pos_mask);
					end else begin
						state_next.err = 1'b1;
					end
					// Single lane answers with no dummy cycles
					state_next.st = (state_next.cnt == 4'h0)
						? bfd_pkg::DEV_ANS : bfd_pkg::DEV_WAIT;
				end
			end
			bfd_pkg::DEV_WAIT: begin
				state_next.cnt = state_reg.cnt - 4'h1;
				if (state_reg.cnt == 4'h1) begin
					state_next.st = bfd_pkg::DEV_ANS;
				end
			end
			bfd_pkg::DEV_ANS: begin
				state_next.st = bfd_pkg::DEV_IDLE;
			end
			default: begin
				state_next.st = bfd_pkg::DEV_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : bfd_device

// ### verilog/bfd_host.sv
// Flash controller end: fetches the descriptor word, then polls the busy
// flag or writes the status byte as it describes. Software drives it over AXI4-Lite.
// Assumes the device answers every command it takes.
//
// Notes on behaviour
// - Bit 31 tells whether busy flag exists
// - Bit 30 set means flag is inverted
// - Bit 29 reserved, reads as zero
// - Bit 28 chooses direct or addressed reads
// - Bit 27 clear: address in lowest byte
// - Bit 27 set: address in byte one
// - Byte-one placement never with 8-bit addressing
// - Bits 26-24 locate flag within status byte
// - Bits 23-16 hold local register address
// - Bit 23 flags octal double-rate support
// - Bit 22 flags octal single-rate support
// - Bit 21 flags quad double-rate support
// - Bit 20 flags quad single-rate support
// - Bits 19-16 give dummy cycle count
// - Single lane reads use no dummy cycles
// - Cleared mode flags never block a mode
// - Bits 15-8 read opcode, zero means none
// - Bits 7-0 write opcode, zero: read-only
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "bfd_consts.svh"
module bfd_host (
	input  wire logic        clk,
	input  wire logic        rst_b,
	bfd_link_if.host         link,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef struct packed {
		bfd_pkg::bfd_host_st_type st;
		bfd_pkg::bfd_job_type     job;
		logic [2:0]               lane;
		logic [31:0]              desc;
		logic                     desc_valid;
		logic                     done;
		logic                     err;
		logic                     absent;
		logic                     flag_busy;
		logic [15:0]              polls;
		logic [7:0]               wbyte;
		logic                     cmd_valid;
		logic [7:0]               cmd_op;
		logic [31:0]              cmd_addr;
		logic                     cmd_has_addr;
		logic [3:0]               cmd_dummy;
		logic [2:0]               cmd_lane;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [1:0]               rresp;
		logic [31:0]              rdata;
	} bfd_host_state_type;
	bfd_host_state_type state_reg;
	bfd_host_state_type state_next;
	logic        wr_go;
	logic        rd_go;
	logic        go_fetch;
	logic        go_poll;
	logic        go_write;
	logic [7:0]  laddr;
	logic [31:0] flag_addr;
	logic [3:0]  dummy;
	logic        flag_now;
	logic [7:0]  rd_op;
	logic [7:0]  wr_op;
	logic [2:0]  lane_now;
// ************************************************************
// Register bus
// ************************************************************
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
	assign rd_go = s_axi_arvalid && !state_reg.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rdata = state_reg.rdata;
	assign go_fetch = wr_go && s_axi_awaddr == `BFD_A_CTRL
		&& s_axi_wstrb[0] && s_axi_wdata[`BFD_C_FETCH]
		&& state_reg.st == bfd_pkg::HOST_IDLE;
	assign go_poll = wr_go && s_axi_awaddr == `BFD_A_CTRL
		&& s_axi_wstrb[0] && s_axi_wdata[`BFD_C_POLL]
		&& state_reg.st == bfd_pkg::HOST_IDLE;
	assign go_write = wr_go && s_axi_awaddr == `BFD_A_CTRL
		&& s_axi_wstrb[0] && s_axi_wdata[`BFD_C_WRITE]
		&& state_reg.st == bfd_pkg::HOST_IDLE;
// ************************************************************
// Descriptor decode
// ************************************************************
	assign laddr = state_reg.desc[`BFD_F_LADR_HI:`BFD_F_LADR_LO];
	assign rd_op = state_reg.desc[`BFD_F_RDOP_HI:`BFD_F_RDOP_LO];
	assign wr_op = state_reg.desc[`BFD_F_WROP_HI:`BFD_F_WROP_LO];
	// Bytes other than the register address are sent as zero,
	// and a direct command carries no address at all
	assign flag_addr = !state_reg.desc[`BFD_F_ADDRD] ? 32'h0
		: state_reg.desc[`BFD_F_BYTE1]
		? {16'h0, laddr, 8'h00}
		: {24'h0, laddr};
	// A lane written together with a start bit applies to that poll or write job; a fetch always uses 1S
	assign lane_now = (wr_go && s_axi_awaddr == `BFD_A_CTRL
		&& s_axi_wstrb[0])
		? s_axi_wdata[`BFD_C_LANE_HI:`BFD_C_LANE_LO] : state_reg.lane;
	// Mode flags are not checked: any lane may be tried
	assign dummy = (state_reg.desc[`BFD_F_ADDRD]
		|| lane_now == 3'(bfd_pkg::LANE_1S)) ? 4'h0
		: state_reg.desc[`BFD_F_DUM_HI:`BFD_F_DUM_LO];
	assign flag_now = link.rsp_data[state_reg.desc[`BFD_F_POS_HI:
		`BFD_F_POS_LO]] ^ state_reg.desc[`BFD_F_POL];
	assign link.cmd_valid = state_reg.cmd_valid;
	assign link.cmd_op = state_reg.cmd_op;
	assign link.cmd_addr = state_reg.cmd_addr;
	assign link.cmd_has_addr = state_reg.cmd_has_addr;
	assign link.cmd_dummy = state_reg.cmd_dummy;
	assign link.cmd_lane = bfd_pkg::bfd_lane_type'(state_reg.cmd_lane);
	assign link.cmd_wdata = state_reg.wbyte;
// ************************************************************
// Sequencer
// ************************************************************
	always_comb begin
		state_next = state_reg;
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (wr_go) begin
			state_next.bvalid = 1'b1;
			state_next.bresp = `BFD_RESP_OK;
			if (s_axi_awaddr == `BFD_A_CTRL) begin
				if (s_axi_wstrb[0]) begin
					state_next.lane =
						s_axi_wdata[`BFD_C_LANE_HI:`BFD_C_LANE_LO];
				end
			end else if (s_axi_awaddr == `BFD_A_WDATA) begin
				if (s_axi_wstrb[0]) begin
					state_next.wbyte = s_axi_wdata[7:0];
				end
			end else if (s_axi_awaddr != `BFD_A_STAT
				&& s_axi_awaddr != `BFD_A_DESC
				&& s_axi_awaddr != `BFD_A_POLLS) begin
				state_next.bresp = `BFD_RESP_ERR;
			end
		end
		if (rd_go) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = `BFD_RESP_OK;
			state_next.rdata = 32'h0;
			unique case (s_axi_araddr)
				`BFD_A_CTRL: state_next.rdata[4:2] = state_reg.lane;
				`BFD_A_STAT: state_next.rdata[5:0] = {state_reg.desc_valid,
					state_reg.err, state_reg.flag_busy, state_reg.absent,
					state_reg.done, state_reg.st != bfd_pkg::HOST_IDLE};
				`BFD_A_DESC: state_next.rdata = state_reg.desc;
				`BFD_A_POLLS: state_next.rdata[15:0] = state_reg.polls;
				`BFD_A_WDATA: state_next.rdata[7:0] = state_reg.wbyte;
				default: state_next.rresp = `BFD_RESP_ERR;
			endcase
		end
		unique case (state_reg.st)
			bfd_pkg::HOST_IDLE: begin
				if (go_fetch || go_poll || go_write) begin
					state_next.done = 1'b0;
					state_next.err = 1'b0;
					state_next.cmd_op = `BFD_OP_DESC;
					state_next.cmd_addr = flag_addr;
					state_next.cmd_has_addr =
						state_reg.desc[`BFD_F_ADDRD];
					state_next.cmd_dummy = dummy;
					state_next.cmd_lane = lane_now;
					state_next.st = bfd_pkg::HOST_SEND;
				end
				if (go_fetch) begin
					state_next.job = bfd_pkg::JOB_FETCH;
					state_next.cmd_addr = 32'h0;
					state_next.cmd_has_addr = 1'b0;
					state_next.cmd_dummy = 4'h0;
					state_next.cmd_lane = 3'(bfd_pkg::LANE_1S);
				end else if (go_poll) begin
					state_next.job = bfd_pkg::JOB_POLL;
					state_next.polls = 16'h0;
					state_next.cmd_op = rd_op;
					if (!state_reg.desc_valid
						|| !state_reg.desc[`BFD_F_AVAIL]
						|| rd_op == `BFD_OP_NONE) begin
						state_next.err = 1'b1;
						state_next.done = 1'b1;
						state_next.st = bfd_pkg::HOST_IDLE;
					end
				end else if (go_write) begin
					state_next.job = bfd_pkg::JOB_WRITE;
					state_next.cmd_op = wr_op;
					if (!state_reg.desc_valid
						|| !state_reg.desc[`BFD_F_AVAIL]
						|| wr_op == `BFD_OP_NONE) begin
						state_next.err = 1'b1;
						state_next.done = 1'b1;
						state_next.st = bfd_pkg::HOST_IDLE;
					end
				end
				state_next.cmd_valid = state_next.st == bfd_pkg::HOST_SEND;
			end
			bfd_pkg::HOST_SEND: begin
				if (link.cmd_ready) begin
					state_next.cmd_valid = 1'b0;
					state_next.st = bfd_pkg::HOST_WAIT;
				end
			end
			bfd_pkg::HOST_WAIT: begin
				if (link.rsp_valid) begin
					state_next.st = bfd_pkg::HOST_IDLE;
					state_next.done = 1'b1;
					if (link.rsp_err) begin
						state_next.err = 1'b1;
					end else if (state_reg.job == bfd_pkg::JOB_FETCH) begin
						state_next.desc = link.rsp_data;
						state_next.desc_valid = 1'b1;
						state_next.absent = !link.rsp_data[`BFD_F_AVAIL];
					end else if (state_reg.job == bfd_pkg::JOB_POLL) begin
						state_next.flag_busy = flag_now;
						state_next.polls = state_reg.polls + 16'h1;
						if (flag_now) begin
							state_next.done = 1'b0;
							state_next.cmd_valid = 1'b1;
							state_next.st = bfd_pkg::HOST_SEND;
						end
					end
				end
			end
			default: begin
				state_next.st = bfd_pkg::HOST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : bfd_host

// ### test/bfd_link_asserts.sv
// Checker for the command and answer link between the two ends.
// Assumes one clock and a host that waits for each answer.
`include "bfd_consts.svh"
module bfd_link_asserts #(
	parameter logic [31:0] DESC_WORD = 32'h0000_0000,
	parameter logic [7:0]  RD_OP     = 8'h05,
	parameter logic [3:0]  DUMMY     = 4'h8
) (
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  cmd_valid,
	input wire logic                  cmd_ready,
	input wire logic [7:0]            cmd_op,
	input wire logic [31:0]           cmd_addr,
	input wire logic                  cmd_has_addr,
	input wire logic [3:0]            cmd_dummy,
	input wire bfd_pkg::bfd_lane_type cmd_lane,
	input wire logic [7:0]            cmd_wdata,
	input wire logic                  rsp_valid,
	input wire logic [31:0]           rsp_data,
	input wire logic                  rsp_err
);
	// ************************************************************
	// Outstanding command and answer delay
	// ************************************************************
	logic       take;
	logic [7:0] op_reg;
	logic       slow_reg;
	logic [4:0] cnt_reg;
	assign take = cmd_valid && cmd_ready;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op_reg <= 8'h00;
			slow_reg <= 1'h0;
			cnt_reg <= 5'h00;
		end else if (take) begin
			op_reg <= cmd_op;
			slow_reg <= cmd_op == RD_OP && !cmd_has_addr
				&& cmd_lane != bfd_pkg::LANE_1S;
			cnt_reg <= 5'h01;
		end else if (rsp_valid) begin
			cnt_reg <= 5'h00;
		end else if (cnt_reg != 5'h00) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	property p_rsp_pulse;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
	property p_latency;
		rsp_valid |-> cnt_reg == (slow_reg ? {1'h0, DUMMY} + 5'h01 : 5'h01);
	endproperty
	a_latency: assert property (p_latency) else $error("answer delay wrong");
	property p_answer;
		take |-> ##[1:17] rsp_valid;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_no_ready;
		take |=> !cmd_ready;
	endproperty
	a_no_ready: assert property (p_no_ready) else $error("ready after take");
	property p_hold;
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
			&& $stable(cmd_dummy) && $stable(cmd_lane) && $stable(cmd_wdata);
	endproperty
	a_hold: assert property (p_hold) else $error("command changed");
	property p_dummy_1s;
		cmd_valid && cmd_op == RD_OP && cmd_lane == bfd_pkg::LANE_1S
			|-> cmd_dummy == 4'h0;
	endproperty
	a_dummy_1s: assert property (p_dummy_1s) else $error("1S dummy");
	property p_dummy_n;
		cmd_valid && cmd_op == RD_OP && !cmd_has_addr
			&& cmd_lane != bfd_pkg::LANE_1S |-> cmd_dummy == DUMMY;
	endproperty
	a_dummy_n: assert property (p_dummy_n) else $error("dummy count");
	property p_direct;
		cmd_valid && cmd_op == RD_OP |-> !cmd_has_addr && cmd_addr == 32'h0;
	endproperty
	a_direct: assert property (p_direct) else $error("direct read style");
	property p_desc;
		rsp_valid && op_reg == `BFD_OP_DESC |-> rsp_data == DESC_WORD && !rsp_err;
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor word");
	property p_status;
		rsp_valid && op_reg == RD_OP |-> rsp_data[31:8] == 24'h0 && !rsp_err;
	endproperty
	a_status: assert property (p_status) else $error("status answer");
	c_fetch: cover property (take && cmd_op == `BFD_OP_DESC);
	c_slow: cover property (take && slow_reg == 1'h0 && cmd_dummy == DUMMY);
	c_1s: cover property (take && cmd_op == RD_OP && cmd_dummy == 4'h0);
	c_write: cover property (take && cmd_op != RD_OP && cmd_op != 8'h5a);
endmodule : bfd_link_asserts

// ### test/tb.sv
// Testbench joining controller and device; drives AXI4-Lite and start_op.
// Assumes the design files and the constants header are compiled first.
`include "bfd_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Device setup, model values and design instances
	// ************************************************************
	localparam logic        POL  = 1'h1;
	localparam logic [2:0]  POS  = 3'h3;
	localparam logic [3:0]  MOD  = 4'ha;
	localparam logic [3:0]  DUM  = 4'h6;
	localparam logic [7:0]  RD   = 8'h05;
	localparam logic [7:0]  WR   = 8'h01;
	localparam logic [31:0] DESC = {1'h1, POL, 3'h0, POS, MOD, DUM, RD, WR};
	localparam logic [7:0]  MSK  = 8'h01 << POS;
	localparam int          BSY  = 20;
	logic        clk = 1'h0;
	logic        rst_b = 1'h0;
	logic        start_op = 1'h0;
	logic        busy;
	logic [7:0]  awaddr, araddr, lf, m_op, m_wd;
	logic [31:0] wdata, rdata, m_rd, rd_d;
	logic [3:0]  wstrb, m_dum;
	logic [2:0]  ln;
	logic [1:0]  bresp, rresp, rd_r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          miscompares = 0;
	int          comparisons = 0;
	int          m_n = 0;
	int          m_bsy = 0;
	logic [7:0]  m_stat = 8'h00;
	logic [31:0] m_q[$];
	bfd_link_if link ();
	bfd_device #(.POL_INV(POL), .FLAG_POS(POS), .MODES(MOD), .DUMMY(DUM),
		.RD_OP(RD), .WR_OP(WR), .BUSY_CYCLES(BSY)) u_bfd_device (.clk(clk),
		.rst_b(rst_b), .link(link), .start_op(start_op), .busy(busy));
	bfd_host u_bfd_host (.clk(clk), .rst_b(rst_b), .link(link),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	bfd_link_asserts #(.DESC_WORD(DESC), .RD_OP(RD), .DUMMY(DUM))
		u_bfd_link_asserts (.clk(clk), .rst_b(rst_b),
		.cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
		.cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr),
		.cmd_has_addr(link.cmd_has_addr), .cmd_dummy(link.cmd_dummy),
		.cmd_lane(link.cmd_lane), .cmd_wdata(link.cmd_wdata),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
		.rsp_err(link.rsp_err));
	always #4 clk = ~clk;
	// Link model: expected answer queued per command, checked per answer
	always @(posedge clk) begin
		if (link.rsp_valid) begin
			m_rd <= link.rsp_data;
			chk(link.rsp_data, m_q.pop_front());
		end
		if (link.cmd_valid && link.cmd_ready) begin
			m_op <= link.cmd_op;
			m_dum <= link.cmd_dummy;
			m_wd <= link.cmd_wdata;
			m_n <= m_n + 1;
			m_q.push_back((link.cmd_op == `BFD_OP_DESC) ? DESC
				: (link.cmd_op == RD) ? {24'h0, (m_stat & ~MSK)
				| (({7'h0, m_bsy != 0} ^ {7'h0, POL}) << POS)}
				: 32'h0);
			if (link.cmd_op == WR) begin
				m_stat <= (link.cmd_wdata & ~MSK) | (m_stat & MSK);
			end
		end
		if (start_op && m_bsy == 0) begin
			m_bsy <= BSY;
		end else if (m_bsy != 0) begin
			m_bsy <= m_bsy - 1;
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task test_done;
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		while (!bvalid) @(posedge clk);
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		while (!rvalid) @(posedge clk);
		rd_d = rdata;
		rd_r = rresp;
	endtask : rd
	task rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_d, e);
	endtask : rchk
	task job(input logic [31:0] c);
		wr(`BFD_A_CTRL, c, `BFD_RESP_OK);
		rd_d = 32'h0;
		while (!rd_d[1]) rd(`BFD_A_STAT);
	endtask : job
	initial begin
		#(8 * 20000);
		miscompares++;
		test_done;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		lf = 8'h5f;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		rchk(`BFD_A_STAT, 32'h0);
		rchk(`BFD_A_DESC, 32'h0);
		rd(8'h14);
		chk({30'h0, rd_r}, {30'h0, `BFD_RESP_ERR});
		chk(rd_d, 32'h0);
		wr(8'h14, 32'hffff_ffff, `BFD_RESP_ERR);
		wr(`BFD_A_DESC, 32'hffff_ffff, `BFD_RESP_OK);
		rchk(`BFD_A_DESC, 32'h0);
		job(32'h2);
		chk(rd_d, 32'h12);
		chk(m_n, 0);
		job(32'h1);
		chk(rd_d, 32'h22);
		chk(m_op, 8'h5a);
		rchk(`BFD_A_DESC, DESC);
		for (ln = 3'h0; ln < 3'h5; ln++) begin
			job({27'h0, ln, 2'h2});
			chk(rd_d, 32'h22);
			chk(m_op, RD);
			chk(m_dum, (ln == 3'h0) ? 4'h0 : DUM);
			chk(m_rd, 32'h8);
			rchk(`BFD_A_POLLS, 32'h1);
		end
		lf = lfsr(lf);
		start_op <= 1'h1;
		@(posedge clk);
		start_op <= 1'h0;
		@(posedge clk);
		chk(busy, 1'h1);
		job({27'h0, 3'(lf % 8'h05), 2'h2});
		chk(rd_d, 32'h22);
		chk(busy, 1'h0);
		rd(`BFD_A_POLLS);
		chk(rd_d > 32'h1, 1'h1);
		lf = lfsr(lf);
		wr(`BFD_A_WDATA, {24'h0, lf}, `BFD_RESP_OK);
		wstrb <= 4'h0;
		wr(`BFD_A_WDATA, 32'h0, `BFD_RESP_OK);
		wstrb <= 4'hf;
		rchk(`BFD_A_WDATA, {24'h0, lf});
		job(32'h20);
		chk(rd_d, 32'h22);
		chk({m_op, m_wd}, {WR, lf});
		job(32'h2);
		chk(m_rd, {24'h0, lf | 8'h08});
		test_done;
	end
endmodule : tb
